/* File: design/tlv_irq_ctrl.sv */
// Notes on behaviour
// - two priority levels; each source placed by its priority bit
// - ext inputs 2, 3 and netcore request on falling edge
// - all request inputs sampled on rising system clock edge
// - ext0 level or falling edge, vector 0x03, order 1, hw clear
// - timer0 overflow, vector 0x0B, order 2, hw clear
// - ext1 level or falling edge, vector 0x13, order 3, hw clear
// - timer1 overflow, vector 0x1B, order 4, hw clear
// - uart tx or rx flag, vector 0x23, order 5, software clears
// - timer2 vector 0x2B, order 6, software clears flag
// - ext2 vector 0x43 order 7, ext3 0x4B order 8, software clears
// - netcore vector 0x5B order 10; input 4 reserved, no vector
// - watchdog vector 0x63, order 11, software clears flag
// - each source gated by its own enable bit
// - global enable bit 7 blocks all; per-source enables bits 0..5
// - software writes set or clear flags like hardware events
// - level mode ext0/1 flag follows pin, writes do not hold
// - trigger select 0 is low level, 1 is falling edge
// - edge-mode ext0, ext1 and timer0, timer1 flags cleared when service begins
// - priority bit 1 is high group, 0 is low group
// - extended enables: ext2 b0, ext3 b1, netcore b3, watchdog b4
// - extended priority bits at the extended enable positions
`timescale 1ns/1ps
`default_nettype none

module tlv_irq_ctrl (
  input  wire logic                i_core_clk,
  input  wire logic                i_srst,
  input  wire tlv_pkg::tlv_bus_t   i_bus,
  output logic [tlv_pkg::DW-1:0]   o_rdata,
  input  wire logic                i_ext_request0_pin_n,
  input  wire logic                i_ext_request1_pin_n,
  input  wire logic                i_ext_request2_pin_n,
  input  wire logic                i_ext_request3_pin_n,
  input  wire logic                i_netcore_request_n,
  input  wire tlv_pkg::tlv_hw_evt_t i_hw_evt,
  input  wire logic                i_irq_ack,
  input  wire logic                i_irq_return,
  output tlv_pkg::tlv_irq_t        o_irq,
  output logic                     o_timer0_run,
  output logic                     o_timer1_run
);

  tlv_pkg::tlv_state_t            state_ff;
  tlv_pkg::tlv_state_t            nxt_state;
  logic [tlv_pkg::NPIN-1:0]       pins;
  logic [tlv_pkg::NPIN-1:0]       stable;
  logic [tlv_pkg::NPIN-1:0]       fall;
  logic [tlv_pkg::NSRC-1:0]       clr;
  logic [tlv_pkg::NSRC-1:0]       pend;
  logic [tlv_pkg::NSRC-1:0]       prio;
  logic                           ack;
  tlv_pkg::tlv_pick_t             pick_hi;
  tlv_pkg::tlv_pick_t             pick_lo;

  function automatic tlv_pkg::tlv_pick_t first_idx(
    input logic [tlv_pkg::NSRC-1:0] v
  );
    tlv_pkg::tlv_pick_t r;
    r = '0;
    for (int i = tlv_pkg::NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r.found = 1'b1;
        r.idx   = tlv_pkg::SRC_W'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] vec_of(
    input logic [tlv_pkg::SRC_W-1:0] idx
  );
    logic [7:0] v;
    case (idx)
      tlv_pkg::SRC_W'(tlv_pkg::S_X0):  v = tlv_pkg::VEC_X0;
      tlv_pkg::SRC_W'(tlv_pkg::S_T0):  v = tlv_pkg::VEC_T0;
      tlv_pkg::SRC_W'(tlv_pkg::S_X1):  v = tlv_pkg::VEC_X1;
      tlv_pkg::SRC_W'(tlv_pkg::S_T1):  v = tlv_pkg::VEC_T1;
      tlv_pkg::SRC_W'(tlv_pkg::S_UA):  v = tlv_pkg::VEC_UA;
      tlv_pkg::SRC_W'(tlv_pkg::S_T2):  v = tlv_pkg::VEC_T2;
      tlv_pkg::SRC_W'(tlv_pkg::S_X2):  v = tlv_pkg::VEC_X2;
      tlv_pkg::SRC_W'(tlv_pkg::S_X3):  v = tlv_pkg::VEC_X3;
      tlv_pkg::SRC_W'(tlv_pkg::S_NET): v = tlv_pkg::VEC_NET;
      tlv_pkg::SRC_W'(tlv_pkg::S_WD):  v = tlv_pkg::VEC_WD;
      default:                         v = 8'h00;
    endcase
    return v;
  endfunction

  assign pins = {i_netcore_request_n, i_ext_request3_pin_n,
                 i_ext_request2_pin_n, i_ext_request1_pin_n,
                 i_ext_request0_pin_n};

  always_comb begin
    nxt_state = state_ff;

    // three-stage sampler; a pin change counts once stages 2 and 3 agree
    nxt_state.s1 = pins;
    nxt_state.s2 = state_ff.s1;
    nxt_state.s3 = state_ff.s2;
    stable = ~(state_ff.s2 ^ state_ff.s3);
    nxt_state.filt = (state_ff.filt & ~stable) | (state_ff.s2 & stable);
    fall = state_ff.filt & stable & ~state_ff.s2;

    // service start clears only the hardware-cleared flags
    ack = i_irq_ack & state_ff.irq.req;
    clr = ack ? (tlv_pkg::NSRC'(1) << state_ff.src) : '0;

    // timer_and_ext_irq_control
    if (i_bus.wr && i_bus.addr == tlv_pkg::OFS_TIMER_AND_EXT_IRQ_CONTROL) begin
      nxt_state.timer_and_ext_irq_control = i_bus.wdata;
    end
    // set wins over any clear in the same cycle
    nxt_state.timer_and_ext_irq_control[tlv_pkg::B_TF0] =
      (nxt_state.timer_and_ext_irq_control[tlv_pkg::B_TF0] & ~clr[tlv_pkg::S_T0])
      | i_hw_evt.timer0_ovf;
    nxt_state.timer_and_ext_irq_control[tlv_pkg::B_TF1] =
      (nxt_state.timer_and_ext_irq_control[tlv_pkg::B_TF1] & ~clr[tlv_pkg::S_T1])
      | i_hw_evt.timer1_ovf;
    if (nxt_state.timer_and_ext_irq_control[tlv_pkg::B_IT0]) begin
      nxt_state.timer_and_ext_irq_control[tlv_pkg::B_IE0] =
        (nxt_state.timer_and_ext_irq_control[tlv_pkg::B_IE0] & ~clr[tlv_pkg::S_X0])
        | fall[tlv_pkg::P_X0];
    end else begin
      // level mode: the flag mirrors the pin, a write cannot hold it
      nxt_state.timer_and_ext_irq_control[tlv_pkg::B_IE0] = ~state_ff.filt[tlv_pkg::P_X0];
    end
    if (nxt_state.timer_and_ext_irq_control[tlv_pkg::B_IT1]) begin
      nxt_state.timer_and_ext_irq_control[tlv_pkg::B_IE1] =
        (nxt_state.timer_and_ext_irq_control[tlv_pkg::B_IE1] & ~clr[tlv_pkg::S_X1])
        | fall[tlv_pkg::P_X1];
    end else begin
      nxt_state.timer_and_ext_irq_control[tlv_pkg::B_IE1] = ~state_ff.filt[tlv_pkg::P_X1];
    end

    // enables and priorities; unimplemented bits stay zero
    if (i_bus.wr && i_bus.addr == tlv_pkg::OFS_IE) begin
      nxt_state.ie = i_bus.wdata & tlv_pkg::IE_MASK;
    end
    if (i_bus.wr && i_bus.addr == tlv_pkg::OFS_IP) begin
      nxt_state.ip = i_bus.wdata & tlv_pkg::IP_MASK;
    end
    if (i_bus.wr && i_bus.addr == tlv_pkg::OFS_EIE) begin
      // reserved input 4 enable is forced to zero
      nxt_state.extended_irq_enable = i_bus.wdata & tlv_pkg::EXT_MASK;
    end
    if (i_bus.wr && i_bus.addr == tlv_pkg::OFS_EIP) begin
      nxt_state.extended_irq_priority = i_bus.wdata & tlv_pkg::EXT_MASK;
    end

    // software-cleared flags: only a write clears, events always set
    if (i_bus.wr && i_bus.addr == tlv_pkg::OFS_EIF) begin
      nxt_state.extended_irq_flags = i_bus.wdata & tlv_pkg::EIF_MASK;
    end
    nxt_state.extended_irq_flags[tlv_pkg::B_X2]  = nxt_state.extended_irq_flags[tlv_pkg::B_X2]
                                    | fall[tlv_pkg::P_X2];
    nxt_state.extended_irq_flags[tlv_pkg::B_X3]  = nxt_state.extended_irq_flags[tlv_pkg::B_X3]
                                    | fall[tlv_pkg::P_X3];
    nxt_state.extended_irq_flags[tlv_pkg::B_NET] = nxt_state.extended_irq_flags[tlv_pkg::B_NET]
                                    | fall[tlv_pkg::P_NET];

    if (i_bus.wr && i_bus.addr == tlv_pkg::OFS_AUX) begin
      nxt_state.aux = i_bus.wdata[3:0] & tlv_pkg::AUX_MASK;
    end
    nxt_state.aux[tlv_pkg::B_T2]  = nxt_state.aux[tlv_pkg::B_T2]
                                    | i_hw_evt.timer2;
    nxt_state.aux[tlv_pkg::B_TX]  = nxt_state.aux[tlv_pkg::B_TX]
                                    | i_hw_evt.uart_tx;
    nxt_state.aux[tlv_pkg::B_RX]  = nxt_state.aux[tlv_pkg::B_RX]
                                    | i_hw_evt.uart_rx;
    nxt_state.aux[tlv_pkg::B_WDF] = nxt_state.aux[tlv_pkg::B_WDF]
                                    | i_hw_evt.wdog;

    // in-service levels: return closes the highest open level first
    if (i_irq_return) begin
      if (state_ff.in_hi) begin
        nxt_state.in_hi = 1'b0;
      end else begin
        nxt_state.in_lo = 1'b0;
      end
    end
    if (ack) begin
      if (state_ff.src_hi) begin
        nxt_state.in_hi = 1'b1;
      end else begin
        nxt_state.in_lo = 1'b1;
      end
    end

    // arbitrate on next-state values so the request drops with the ack
    pend = '0;
    pend[tlv_pkg::S_X0]  = nxt_state.timer_and_ext_irq_control[tlv_pkg::B_IE0]
                           & nxt_state.ie[tlv_pkg::S_X0];
    pend[tlv_pkg::S_T0]  = nxt_state.timer_and_ext_irq_control[tlv_pkg::B_TF0]
                           & nxt_state.ie[tlv_pkg::S_T0];
    pend[tlv_pkg::S_X1]  = nxt_state.timer_and_ext_irq_control[tlv_pkg::B_IE1]
                           & nxt_state.ie[tlv_pkg::S_X1];
    pend[tlv_pkg::S_T1]  = nxt_state.timer_and_ext_irq_control[tlv_pkg::B_TF1]
                           & nxt_state.ie[tlv_pkg::S_T1];
    pend[tlv_pkg::S_UA]  = (nxt_state.aux[tlv_pkg::B_TX]
                           | nxt_state.aux[tlv_pkg::B_RX])
                           & nxt_state.ie[tlv_pkg::S_UA];
    pend[tlv_pkg::S_T2]  = nxt_state.aux[tlv_pkg::B_T2]
                           & nxt_state.ie[tlv_pkg::S_T2];
    pend[tlv_pkg::S_X2]  = nxt_state.extended_irq_flags[tlv_pkg::B_X2]
                           & nxt_state.extended_irq_enable[tlv_pkg::B_X2];
    pend[tlv_pkg::S_X3]  = nxt_state.extended_irq_flags[tlv_pkg::B_X3]
                           & nxt_state.extended_irq_enable[tlv_pkg::B_X3];
    pend[tlv_pkg::S_NET] = nxt_state.extended_irq_flags[tlv_pkg::B_NET]
                           & nxt_state.extended_irq_enable[tlv_pkg::B_NET];
    pend[tlv_pkg::S_WD]  = nxt_state.aux[tlv_pkg::B_WDF]
                           & nxt_state.extended_irq_enable[tlv_pkg::B_WD];
    pend = pend & {tlv_pkg::NSRC{nxt_state.ie[tlv_pkg::B_GEN]}};

    prio = {nxt_state.extended_irq_priority[tlv_pkg::B_WD], nxt_state.extended_irq_priority[tlv_pkg::B_NET],
            nxt_state.extended_irq_priority[tlv_pkg::B_X3], nxt_state.extended_irq_priority[tlv_pkg::B_X2],
            nxt_state.ip[5:0]};
    pick_hi = first_idx(pend & prio);
    pick_lo = first_idx(pend & ~prio);

    nxt_state.irq.req = 1'b0;
    if (pick_hi.found && !nxt_state.in_hi) begin
      nxt_state.irq.req = 1'b1;
      nxt_state.src     = pick_hi.idx;
      nxt_state.src_hi  = 1'b1;
    end else if (pick_lo.found && !nxt_state.in_hi && !nxt_state.in_lo) begin
      nxt_state.irq.req = 1'b1;
      nxt_state.src     = pick_lo.idx;
      nxt_state.src_hi  = 1'b0;
    end
    nxt_state.irq.vector = nxt_state.irq.req ? vec_of(nxt_state.src)
                                             : 8'h00;

    // read data stands only in the cycle after the strobe
    nxt_state.rdata = tlv_pkg::RST8;
    if (i_bus.rd) begin
      case (i_bus.addr)
        tlv_pkg::OFS_TIMER_AND_EXT_IRQ_CONTROL: nxt_state.rdata = state_ff.timer_and_ext_irq_control;
        tlv_pkg::OFS_EIF:  nxt_state.rdata = state_ff.extended_irq_flags;
        tlv_pkg::OFS_IE:   nxt_state.rdata = state_ff.ie;
        tlv_pkg::OFS_IP:   nxt_state.rdata = state_ff.ip;
        tlv_pkg::OFS_EIE:  nxt_state.rdata = state_ff.extended_irq_enable;
        tlv_pkg::OFS_EIP:  nxt_state.rdata = state_ff.extended_irq_priority;
        tlv_pkg::OFS_AUX:  nxt_state.rdata = {4'h0, state_ff.aux};
        default:           nxt_state.rdata = tlv_pkg::RST8;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_ff <= tlv_pkg::STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_rdata      = state_ff.rdata;
  assign o_irq        = state_ff.irq;
  assign o_timer0_run = state_ff.timer_and_ext_irq_control[tlv_pkg::B_TR0];
  assign o_timer1_run = state_ff.timer_and_ext_irq_control[tlv_pkg::B_TR1];

endmodule

`default_nettype wire

/* File: design/tlv_pkg.sv */
package tlv_pkg;

  localparam int unsigned AW     = 8;
  localparam int unsigned DW     = 8;
  localparam int unsigned NSRC   = 10;
  localparam int unsigned SRC_W  = 4;
  localparam int unsigned NPIN   = 5;

  // register offsets
  localparam logic [AW-1:0] OFS_TIMER_AND_EXT_IRQ_CONTROL = 8'h88;
  localparam logic [AW-1:0] OFS_EIF  = 8'h91;
  localparam logic [AW-1:0] OFS_IE   = 8'ha8;
  localparam logic [AW-1:0] OFS_IP   = 8'hb8;
  localparam logic [AW-1:0] OFS_EIE  = 8'he8;
  localparam logic [AW-1:0] OFS_AUX  = 8'hef;
  localparam logic [AW-1:0] OFS_EIP  = 8'hf8;

  localparam logic [DW-1:0] RST8     = 8'h00;
  localparam logic [DW-1:0] IE_MASK  = 8'hbf;
  localparam logic [DW-1:0] IP_MASK  = 8'h3f;
  localparam logic [DW-1:0] EXT_MASK = 8'h1b;
  localparam logic [DW-1:0] EIF_MASK = 8'h0b;
  localparam logic [3:0]    AUX_MASK = 4'hf;

  // timer_and_ext_irq_control bits
  localparam int unsigned B_IT0 = 0;
  localparam int unsigned B_IE0 = 1;
  localparam int unsigned B_IT1 = 2;
  localparam int unsigned B_IE1 = 3;
  localparam int unsigned B_TR0 = 4;
  localparam int unsigned B_TF0 = 5;
  localparam int unsigned B_TR1 = 6;
  localparam int unsigned B_TF1 = 7;
  // interrupt_enable global bit
  localparam int unsigned B_GEN = 7;
  // extended enable / priority bits; flag bits for ext2, ext3, netcore only
  localparam int unsigned B_X2  = 0;
  localparam int unsigned B_X3  = 1;
  localparam int unsigned B_NET = 3;
  localparam int unsigned B_WD  = 4;
  // aux flag register bits
  localparam int unsigned B_T2  = 0;
  localparam int unsigned B_TX  = 1;
  localparam int unsigned B_RX  = 2;
  localparam int unsigned B_WDF = 3;

  // pin index inside the synchroniser vector
  localparam int unsigned P_X0  = 0;
  localparam int unsigned P_X1  = 1;
  localparam int unsigned P_X2  = 2;
  localparam int unsigned P_X3  = 3;
  localparam int unsigned P_NET = 4;

  // source index = natural priority order, 0 is served first
  localparam int unsigned S_X0  = 0;
  localparam int unsigned S_T0  = 1;
  localparam int unsigned S_X1  = 2;
  localparam int unsigned S_T1  = 3;
  localparam int unsigned S_UA  = 4;
  localparam int unsigned S_T2  = 5;
  localparam int unsigned S_X2  = 6;
  localparam int unsigned S_X3  = 7;
  localparam int unsigned S_NET = 8;
  localparam int unsigned S_WD  = 9;

  localparam logic [7:0] VEC_X0  = 8'h03;
  localparam logic [7:0] VEC_T0  = 8'h0b;
  localparam logic [7:0] VEC_X1  = 8'h13;
  localparam logic [7:0] VEC_T1  = 8'h1b;
  localparam logic [7:0] VEC_UA  = 8'h23;
  localparam logic [7:0] VEC_T2  = 8'h2b;
  localparam logic [7:0] VEC_X2  = 8'h43;
  localparam logic [7:0] VEC_X3  = 8'h4b;
  localparam logic [7:0] VEC_NET = 8'h5b;
  localparam logic [7:0] VEC_WD  = 8'h63;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } tlv_bus_t;

  typedef struct packed {
    logic timer0_ovf;
    logic timer1_ovf;
    logic timer2;
    logic uart_tx;
    logic uart_rx;
    logic wdog;
  } tlv_hw_evt_t;

  typedef struct packed {
    logic       req;
    logic [7:0] vector;
  } tlv_irq_t;

  typedef struct packed {
    logic             found;
    logic [SRC_W-1:0] idx;
  } tlv_pick_t;

  typedef struct packed {
    logic [NPIN-1:0]  s1;
    logic [NPIN-1:0]  s2;
    logic [NPIN-1:0]  s3;
    logic [NPIN-1:0]  filt;
    logic [DW-1:0]    timer_and_ext_irq_control;
    logic [DW-1:0]    ie;
    logic [DW-1:0]    ip;
    logic [DW-1:0]    extended_irq_enable;
    logic [DW-1:0]    extended_irq_priority;
    logic [DW-1:0]    extended_irq_flags;
    logic [3:0]       aux;
    logic             in_hi;
    logic             in_lo;
    logic             src_hi;
    logic [SRC_W-1:0] src;
    tlv_irq_t         irq;
    logic [DW-1:0]    rdata;
  } tlv_state_t;

  // pins idle high, so the synchronisers start high to avoid a false edge
  localparam tlv_state_t STATE_RST = '{
    s1: '1, s2: '1, s3: '1, filt: '1, default: '0};

endpackage

/* File: tb/tlv_irq_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module tlv_chk (
  input wire logic                   i_core_clk,
  input wire logic                   i_srst,
  input wire tlv_pkg::tlv_bus_t      i_bus,
  input wire logic [tlv_pkg::DW-1:0] o_rdata,
  input wire logic                   i_irq_ack,
  input wire logic                   i_irq_return,
  input wire tlv_pkg::tlv_irq_t      o_irq
);
  logic [7:0] ie_ff;
  logic [7:0] eie_ff;
  // enable shadows rebuilt from bus writes, the checker cannot see inside
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ie_ff  <= 8'h00;
      eie_ff <= 8'h00;
    end else if (i_bus.wr) begin
      if (i_bus.addr == 8'ha8) ie_ff <= i_bus.wdata;
      if (i_bus.addr == 8'he8) eie_ff <= i_bus.wdata;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  chk_vec_idle: assert property (
    !o_irq.req |-> o_irq.vector == 8'h00) else $error("stray vector");
  chk_vec_legal: assert property (
    o_irq.req |-> o_irq.vector inside {8'h03, 8'h0b, 8'h13, 8'h1b,
      8'h23, 8'h2b, 8'h43, 8'h4b, 8'h5b, 8'h63})
    else $error("unknown vector");
  chk_gen_gate: assert property (
    o_irq.req |-> ie_ff[7]) else $error("request with global off");
  chk_src_gate: assert property (
    o_irq.req |-> (o_irq.vector[6] ? eie_ff[o_irq.vector[5:3]]
                                   : ie_ff[o_irq.vector[5:3]]))
    else $error("request from disabled source");
  chk_ack_drop: assert property (
    o_irq.req && i_irq_ack && !i_irq_return |=>
      !o_irq.req || o_irq.vector != $past(o_irq.vector))
    else $error("acked request still shown");
  chk_req_hold: assert property (
    o_irq.req && !i_irq_ack && !i_bus.wr &&
      !(o_irq.vector inside {8'h03, 8'h13}) |=> o_irq.req)
    else $error("request dropped early");
  chk_ie_read: assert property (
    $past(i_bus.rd && i_bus.addr == 8'ha8) |-> o_rdata == (ie_ff & 8'hbf))
    else $error("enable read wrong");
  chk_eie_read: assert property (
    $past(i_bus.rd && i_bus.addr == 8'he8) |-> o_rdata == (eie_ff & 8'h1b))
    else $error("extended enable read wrong");
endmodule
bind tlv_irq_ctrl tlv_chk chk_u (
  .i_core_clk(i_core_clk), .i_srst(i_srst), .i_bus(i_bus),
  .o_rdata(o_rdata), .i_irq_ack(i_irq_ack),
  .i_irq_return(i_irq_return), .o_irq(o_irq));
`default_nettype wire

/* File: tb/tlv_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tlv_src_model (
  input  wire logic            i_core_clk,
  output tlv_pkg::tlv_hw_evt_t o_evt,
  output logic [4:0]           o_pin_n
);
  initial begin
    o_pin_n = 5'h1f;
    o_evt = '0;
  end
  // a request is a high-to-low step held past the two-stage filter
  task fall(input int i, input int n);
    o_pin_n[i] <= 1'b0;
    repeat (n) @(posedge i_core_clk);
    o_pin_n[i] <= 1'b1;
  endtask
  task level(input int i, input logic v);
    o_pin_n[i] <= v;
  endtask
  task pulse(input int i);
    o_evt <= tlv_pkg::tlv_hw_evt_t'(6'h01 << i);
    @(posedge i_core_clk);
    o_evt <= '0;
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                 i_core_clk;
  logic                 i_srst;
  tlv_pkg::tlv_bus_t    i_bus;
  logic [7:0]           o_rdata;
  logic                 i_irq_ack;
  logic                 i_irq_return;
  tlv_pkg::tlv_irq_t    o_irq;
  tlv_pkg::tlv_hw_evt_t i_hw_evt;
  logic [4:0]           pin_n;
  logic                 run0;
  logic                 run1;
  int                   mismatches;
  int                   check_count;
  logic [7:0] regs [8] = '{8'h88, 8'h91, 8'ha8, 8'hb8, 8'he8, 8'hef,
                           8'hf8, 8'h10};
  logic [7:0] masks [8] = '{8'hff, 8'h0b, 8'hbf, 8'h3f, 8'h1b, 8'h0f,
                            8'h1b, 8'h00};
  logic [7:0] sa [11] = '{8'h88, 8'h88, 8'h88, 8'h88, 8'hef, 8'hef,
                          8'hef, 8'h91, 8'h91, 8'h91, 8'hef};
  logic [7:0] sd [11] = '{8'h07, 8'h25, 8'h0d, 8'h85, 8'h02, 8'h04,
                          8'h01, 8'h01, 8'h02, 8'h08, 8'h08};
  logic [7:0] sv [11] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h23,
                          8'h2b, 8'h43, 8'h4b, 8'h5b, 8'h63};
  tlv_irq_ctrl dut_u (
    .i_core_clk, .i_srst, .i_bus, .o_rdata,
    .i_ext_request0_pin_n(pin_n[0]), .i_ext_request1_pin_n(pin_n[1]),
    .i_ext_request2_pin_n(pin_n[2]), .i_ext_request3_pin_n(pin_n[3]),
    .i_netcore_request_n(pin_n[4]), .i_hw_evt, .i_irq_ack,
    .i_irq_return, .o_irq, .o_timer0_run(run0), .o_timer1_run(run1));
  tlv_src_model src_u (.i_core_clk, .o_evt(i_hw_evt), .o_pin_n(pin_n));
  task tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task chk8(input string s, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    i_bus <= '{a, v, 1'b1, 1'b0};
    tick(1);
    i_bus <= '0;
    tick(1);
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_bus <= '{a, 8'h00, 1'b0, 1'b1};
    tick(1);
    i_bus <= '0;
    #1 chk8($sformatf("reg %h", a), e, o_rdata);
    tick(1);
  endtask
  // sampled 1 ns after the edge so the design's updates have landed;
  // the closing tick puts the next drive back on a rising edge
  task irq_is(input logic r, input logic [7:0] v);
    #1 chk8("req", {7'h00, r}, {7'h00, o_irq.req});
    chk8("vector", v, o_irq.vector);
    tick(1);
  endtask
  task core(input logic a);
    i_irq_ack <= a;
    i_irq_return <= !a;
    tick(1);
    i_irq_ack <= 1'b0;
    i_irq_return <= 1'b0;
    tick(1);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  initial begin
    tick(20000);
    mismatches++;
    summarize();
  end
  initial begin
    i_srst = 1'b1;
    i_bus = '0;
    i_irq_ack = 1'b0;
    i_irq_return = 1'b0;
    mismatches = 0;
    check_count = 0;
    tick(2);
    i_srst <= 1'b0;
    foreach (regs[i]) begin
      rd_chk(regs[i], 8'h00);
      wr(regs[i], 8'hff);
      rd_chk(regs[i], masks[i]);
    end
    foreach (regs[i]) wr(regs[i], 8'h00);
    irq_is(1'b0, 8'h00);
    wr(8'h88, 8'h50);
    chk8("timer run", 8'h03, {6'h00, run1, run0});
    wr(8'h88, 8'h05);
    chk8("timer run", 8'h00, {6'h00, run1, run0});
    wr(8'he8, 8'h1b);
    wr(8'ha8, 8'h3f);
    wr(8'h88, 8'h25);
    irq_is(1'b0, 8'h00);
    wr(8'ha8, 8'hbd);
    irq_is(1'b0, 8'h00);
    wr(8'ha8, 8'hbf);
    irq_is(1'b1, 8'h0b);
    wr(8'h88, 8'h05);
    wr(8'h91, 8'h04);
    irq_is(1'b0, 8'h00);
    foreach (sa[i]) begin
      wr(sa[i], sd[i]);
      irq_is(1'b1, sv[i]);
      wr(sa[i], sa[i] == 8'h88 ? 8'h05 : 8'h00);
      irq_is(1'b0, 8'h00);
    end
    wr(8'h88, 8'haf);
    wr(8'hef, 8'h0f);
    wr(8'h91, 8'h0b);
    irq_is(1'b1, 8'h03);
    wr(8'hb8, 8'h20);
    irq_is(1'b1, 8'h2b);
    wr(8'hb8, 8'h00);
    wr(8'hf8, 8'h10);
    irq_is(1'b1, 8'h63);
    core(1'b1);
    irq_is(1'b0, 8'h00);
    core(1'b0);
    irq_is(1'b1, 8'h63);
    wr(8'hef, 8'h07);
    irq_is(1'b1, 8'h03);
    core(1'b1);
    rd_chk(8'h88, 8'had);
    wr(8'hf8, 8'h01);
    irq_is(1'b1, 8'h43);
    core(1'b1);
    irq_is(1'b0, 8'h00);
    core(1'b0);
    irq_is(1'b1, 8'h43);
    wr(8'h91, 8'h0a);
    irq_is(1'b0, 8'h00);
    core(1'b0);
    irq_is(1'b1, 8'h0b);
    core(1'b1);
    rd_chk(8'h88, 8'h8d);
    core(1'b0);
    irq_is(1'b1, 8'h13);
    core(1'b1);
    core(1'b0);
    irq_is(1'b1, 8'h1b);
    core(1'b1);
    rd_chk(8'h88, 8'h05);
    core(1'b0);
    irq_is(1'b1, 8'h23);
    wr(8'hef, 8'h01);
    irq_is(1'b1, 8'h2b);
    core(1'b1);
    irq_is(1'b0, 8'h00);
    core(1'b0);
    irq_is(1'b1, 8'h2b);
    foreach (regs[i]) wr(regs[i], 8'h00);
    for (int i = 2; i < 5; i++) begin
      src_u.fall(i, 3);
      tick(6);
      rd_chk(8'h91, i == 4 ? 8'h08 : 8'(i - 1));
      wr(8'h91, 8'h00);
    end
    for (int i = 0; i < 2; i++) begin
      src_u.level(i, 1'b0);
      tick(6);
      rd_chk(8'h88, 8'h02 << 2 * i);
      wr(8'h88, 8'h00);
      rd_chk(8'h88, 8'h02 << 2 * i);
      src_u.level(i, 1'b1);
      tick(6);
      rd_chk(8'h88, 8'h00);
      wr(8'h88, 8'h01 << 2 * i);
      src_u.fall(i, 3);
      tick(6);
      rd_chk(8'h88, 8'h03 << 2 * i);
      wr(8'h88, 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      src_u.pulse(i);
      tick(1);
      rd_chk(i < 4 ? 8'hef : 8'h88,
             i < 4 ? 8'h08 >> i : 8'h80 >> 2 * (i - 4));
      wr(i < 4 ? 8'hef : 8'h88, 8'h00);
    end
    wr(8'ha8, 8'hbf);
    i_srst <= 1'b1;
    tick(2);
    i_srst <= 1'b0;
    rd_chk(8'ha8, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
